// ---- rtl/chef_pkg.sv ----
// Constants, field widths and carrier types shared by the control header framer.
package chef_pkg;
  // ==========================================================================
  // Register map (byte addresses on the APB word bus)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_FIELDS = 8'h04;
  localparam logic [7:0] ADDR_RATE   = 8'h08;
  localparam logic [7:0] ADDR_ACK_LO = 8'h0C;
  localparam logic [7:0] ADDR_ACK_HI = 8'h10;
  localparam logic [7:0] ADDR_VALID  = 8'h14;
  localparam logic [7:0] ADDR_CQI    = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_LAST   = 8'h20;
  // ==========================================================================
  // Control register bit positions
  localparam int CTRL_KIND_LSB = 0;
  localparam int CTRL_VER2     = 3;
  localparam int CTRL_SC       = 4;
  localparam int CTRL_ACK_TWO  = 5;
  localparam int CTRL_LEN3     = 6;
  localparam int CTRL_SOUND    = 7;
  localparam int CTRL_ACK_LSB  = 8;
  localparam int CTRL_GO_HDR   = 10;
  localparam int CTRL_GO_ACK   = 11;
  localparam int CTRL_GO_CQI   = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ==========================================================================
  // Header field widths and codes
  localparam int HDR_W      = 256;
  localparam int SIG_W      = 4;
  localparam int W_REQ      = 7;
  localparam int W_ACK      = 36;
  localparam int W_VALID    = 20;
  localparam int W_RATE     = 16;
  localparam int W_RSV_OFDM = 64;
  localparam int W_RSV_SC   = 6;
  localparam int W_AMR      = 4;
  localparam int W_CQI      = 20;
  localparam int CQI_A_MAX  = 13;
  localparam int CQI_SYMS   = 10;
  localparam logic [1:0] CI_INITIAL  = 2'b00;
  localparam logic [1:0] CI_EXTENDED = 2'b01;
  localparam logic [1:0] CI_TRAFFIC  = 2'b00;
  localparam logic [1:0] CI_CIRCUIT  = 2'b01;
  localparam logic [1:0] SHIFT_STAY  = 2'b00;
  localparam logic [1:0] SHIFT_BACK1 = 2'b01;
  localparam logic [1:0] SHIFT_FWD2  = 2'b10;
  localparam logic [1:0] SHIFT_FWD1  = 2'b11;
  localparam int DATA_LEN4 = 4;
  localparam int DATA_LEN3 = 3;

  typedef enum logic [2:0] {
    KIND_INITIAL  = 3'h0,
    KIND_EXTENDED = 3'h1,
    KIND_CIRCUIT  = 3'h2,
    KIND_TRAFFIC  = 3'h3,
    KIND_MIMO_EXT = 3'h4
  } chef_kind_t;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_SIG  = 3'b010,
    SER_HDR  = 3'b100
  } chef_ser_t;

  typedef struct packed {
    logic signed [1:0] re;
    logic signed [1:0] im;
  } chef_sym_t;

  // Fields of a received downlink header, as decoded by the modem.
  typedef struct packed {
    logic [1:0]  shift;
    logic        ppow;
    logic        pow;
    logic [3:0]  rate_req;
    logic [3:0]  prate_req;
    logic [1:0]  mtype;
    logic [1:0]  aux;
    logic [1:0]  sched;
    logic [9:0]  band;
    logic        grant;
  } chef_dl_t;

  typedef struct packed {
    logic [255:0] bits;
    logic [8:0]   len;
  } chef_hdr_t;
endpackage : chef_pkg

// ---- rtl/chef_framer.sv ----
// Uplink control header framer with downlink error fallback and ack/quality mappers.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module chef_framer #(
  parameter int W_RSV_V2 = 8,
  parameter int W_ACK_V2 = 36,
  parameter int W_VAL_V2 = 20,
  parameter int W_RATE_V2 = 4
) (
  input  wire logic                clock_in,
  input  wire logic                rst_b_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [7:0]          paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  input  wire logic                data_block_in,
  input  wire logic                dl_hdr_valid_in,
  input  wire logic                dl_crc_ok_in,
  input  wire chef_pkg::chef_dl_t  dl_fields_in,
  output logic                     hdr_bit_out,
  output logic                     hdr_valid_out,
  output logic                     hdr_crc_en_out,
  output logic                     hdr_last_out,
  output chef_pkg::chef_sym_t      ack_sym_out,
  output logic                     ack_valid_out,
  output logic                     ack_puncture_out,
  output chef_pkg::chef_sym_t      cqi_sym_out,
  output logic                     cqi_valid_out,
  output logic signed [7:0]        timing_offset_out,
  output logic signed [7:0]        power_level_out,
  output logic signed [7:0]        primary_power_out,
  output logic                     dl_fallback_out,
  output chef_pkg::chef_dl_t       dl_effective_out
);
  // ==========================================================================
  // Functions
  function automatic chef_pkg::chef_hdr_t put(input chef_pkg::chef_hdr_t h,
                                              input logic [71:0] v, input int w);
    chef_pkg::chef_hdr_t r;
    r = h;
    for (int j = 0; j < 72; j++) begin
      if (j < w && (int'(h.len) + j) < chef_pkg::HDR_W) begin
        r.bits[chef_pkg::HDR_W - 1 - int'(h.len) - j] = v[w - 1 - j];
      end
    end
    r.len = h.len + 9'(w);
    return r;
  endfunction : put

  function automatic chef_pkg::chef_sym_t ack_map(input logic two, input logic [1:0] b);
    chef_pkg::chef_sym_t s;
    s = '{re: 2'sb01, im: 2'sb00};
    if (!two) begin
      if (b[0]) s.re = 2'sb11;
    end else begin
      case (b)
        2'b00:   s = '{re: 2'sb01, im: 2'sb00};
        2'b01:   s = '{re: 2'sb00, im: 2'sb11};
        2'b10:   s = '{re: 2'sb00, im: 2'sb01};
        default: s = '{re: 2'sb11, im: 2'sb00};
      endcase
    end
    return s;
  endfunction : ack_map

  // Basis row for coded bit i; a plain pattern that software cannot change.
  function automatic logic cqi_basis(input int i, input int k);
    logic [7:0] p;
    p = 8'((i + 1) * (k + 3) + k);
    return p[2] ^ p[0];
  endfunction : cqi_basis

  function automatic logic signed [7:0] sat_add(input logic signed [7:0] a,
                                               input logic signed [2:0] d);
    logic signed [8:0] s;
    s = 9'(a) + 9'(d);
    if (s > 9'sd127) return 8'sh7F;
    if (s < -9'sd128) return 8'sh80;
    return s[7:0];
  endfunction : sat_add

  // ==========================================================================
  // Register file
  logic [31:0] ctrl_reg, fields_reg, rate_reg, ack_lo_reg, valid_reg, cqi_reg;
  logic [3:0]  ack_hi_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg, pslverr_reg;
  logic        fail_reg;
  chef_pkg::chef_dl_t eff_reg;
  logic signed [7:0] timing_reg, power_reg, ppower_reg;
  chef_pkg::chef_ser_t ser_reg;
  logic        ack_act_reg, cqi_act_reg;

  wire setup_w = psel_in & ~penable_in;
  wire wr_w    = psel_in & penable_in & pready_reg & pwrite_in;
  wire hit_w   = (paddr_in[1:0] == 2'b00) && (paddr_in <= chef_pkg::ADDR_LAST);
  wire [31:0] status_w = {8'h00, power_reg, timing_reg, 4'h0, fail_reg,
                          cqi_act_reg, ack_act_reg, ser_reg != chef_pkg::SER_IDLE};
  wire [31:0] last_w = {7'h00, eff_reg.grant, eff_reg.aux, eff_reg.mtype,
                        eff_reg.band, eff_reg.sched, eff_reg.prate_req, eff_reg.rate_req};
  logic [31:0] rd_w;
  always_comb begin
    case (paddr_in)
      chef_pkg::ADDR_CTRL:   rd_w = ctrl_reg;
      chef_pkg::ADDR_FIELDS: rd_w = fields_reg;
      chef_pkg::ADDR_RATE:   rd_w = rate_reg;
      chef_pkg::ADDR_ACK_LO: rd_w = ack_lo_reg;
      chef_pkg::ADDR_ACK_HI: rd_w = {28'h0, ack_hi_reg};
      chef_pkg::ADDR_VALID:  rd_w = valid_reg;
      chef_pkg::ADDR_CQI:    rd_w = cqi_reg;
      chef_pkg::ADDR_STATUS: rd_w = status_w;
      chef_pkg::ADDR_LAST:   rd_w = last_w;
      default:               rd_w = 32'h0000_0000;
    endcase
  end

  wire go_hdr_w = wr_w && paddr_in == chef_pkg::ADDR_CTRL && pwdata_in[chef_pkg::CTRL_GO_HDR];
  wire go_ack_w = wr_w && paddr_in == chef_pkg::ADDR_CTRL && pwdata_in[chef_pkg::CTRL_GO_ACK];
  wire go_cqi_w = wr_w && paddr_in == chef_pkg::ADDR_CTRL && pwdata_in[chef_pkg::CTRL_GO_CQI];

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg    <= chef_pkg::CTRL_RESET;
      fields_reg  <= 32'h0000_0000;
      rate_reg    <= 32'h0000_0000;
      ack_lo_reg  <= 32'h0000_0000;
      ack_hi_reg  <= 4'h0;
      valid_reg   <= 32'h0000_0000;
      cqi_reg     <= 32'h0000_0000;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_w;
      pslverr_reg <= setup_w & ~hit_w;
      prdata_reg  <= setup_w ? rd_w : 32'h0000_0000;
      if (wr_w) begin
        case (paddr_in)
          chef_pkg::ADDR_CTRL:   ctrl_reg   <= pwdata_in;
          chef_pkg::ADDR_FIELDS: fields_reg <= pwdata_in;
          chef_pkg::ADDR_RATE:   rate_reg   <= pwdata_in;
          chef_pkg::ADDR_ACK_LO: ack_lo_reg <= pwdata_in;
          chef_pkg::ADDR_ACK_HI: ack_hi_reg <= pwdata_in[3:0];
          chef_pkg::ADDR_VALID:  valid_reg  <= pwdata_in;
          chef_pkg::ADDR_CQI:    cqi_reg    <= pwdata_in;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Downlink header intake and error fallback
  logic signed [2:0] tstep_w;
  always_comb begin
    case (dl_fields_in.shift)
      chef_pkg::SHIFT_BACK1: tstep_w = -3'sd1;
      chef_pkg::SHIFT_FWD2:  tstep_w = 3'sd2;
      chef_pkg::SHIFT_FWD1:  tstep_w = 3'sd1;
      default:               tstep_w = 3'sd0;
    endcase
  end
  wire signed [2:0] pstep_w  = dl_fields_in.pow ? 3'sd1 : -3'sd1;
  wire signed [2:0] ppstep_w = dl_fields_in.ppow ? 3'sd1 : -3'sd1;
  wire dl_good_w = dl_hdr_valid_in & dl_crc_ok_in;
  wire dl_bad_w  = dl_hdr_valid_in & ~dl_crc_ok_in;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fail_reg   <= 1'b0;
      eff_reg    <= '0;
      timing_reg <= 8'sd0;
      power_reg  <= 8'sd0;
      ppower_reg <= 8'sd0;
    end else if (dl_good_w) begin
      fail_reg   <= 1'b0;
      eff_reg    <= dl_fields_in;
      timing_reg <= sat_add(timing_reg, tstep_w);
      power_reg  <= sat_add(power_reg, pstep_w);
      ppower_reg <= sat_add(ppower_reg, ppstep_w);
    end else if (dl_bad_w) begin
      // Timing and power stay put while the last valid rates are kept.
      fail_reg      <= 1'b1;
      eff_reg.grant <= 1'b0;
      eff_reg.mtype <= 2'b00;
      eff_reg.aux   <= 2'b00;
    end
  end

  // ==========================================================================
  // Uplink header build
  wire chef_pkg::chef_kind_t kind_w = chef_pkg::chef_kind_t'(ctrl_reg[2:0]);
  wire        ver2_w   = ctrl_reg[chef_pkg::CTRL_VER2];
  wire [6:0]  req_w    = fields_reg[6:0];
  wire        ppow_w   = fields_reg[7];
  wire        pow_w    = fields_reg[8];
  wire [3:0]  amr_w    = fields_reg[12:9];
  wire [1:0]  mtype_w  = fields_reg[14:13];
  wire [1:0]  aux_w    = fields_reg[16:15];
  wire [1:0]  sched_w  = fields_reg[18:17];
  wire        cancel_w = fields_reg[19] | fail_reg;
  wire [35:0] ack_w    = fail_reg ? {36{1'b1}} : {ack_hi_reg, ack_lo_reg};
  wire [19:0] val_w    = fail_reg ? 20'h0_0000 : valid_reg[19:0];
  wire [15:0] mi_w     = rate_reg[15:0];
  wire [15:0] mr_w     = rate_reg[31:16];

  chef_pkg::chef_hdr_t hdr_w;
  logic [3:0] sig_w;
  logic       sig_en_w;
  always_comb begin
    hdr_w    = '0;
    sig_w    = mi_w[3:0];
    sig_en_w = 1'b0;
    case (kind_w)
      chef_pkg::KIND_INITIAL: begin
        sig_en_w = ver2_w;
        hdr_w = put(hdr_w, 72'(chef_pkg::CI_INITIAL), 2);
        hdr_w = put(hdr_w, 72'(ppow_w), 1);
        if (ver2_w) hdr_w = put(hdr_w, 72'(amr_w), chef_pkg::W_AMR);
      end
      chef_pkg::KIND_EXTENDED: begin
        sig_en_w = ver2_w;
        hdr_w = put(hdr_w, 72'(chef_pkg::CI_EXTENDED), 2);
        if (!ver2_w) begin
          hdr_w = put(hdr_w, 72'(req_w), chef_pkg::W_REQ);
          hdr_w = put(hdr_w, 72'(ppow_w), 1);
          hdr_w = put(hdr_w, 72'(pow_w), 1);
          hdr_w = put(hdr_w, 72'(ack_w), chef_pkg::W_ACK);
          hdr_w = put(hdr_w, 72'(val_w), chef_pkg::W_VALID);
          hdr_w = put(hdr_w, 72'(mi_w), chef_pkg::W_RATE);
          hdr_w = put(hdr_w, 72'(mr_w), chef_pkg::W_RATE);
          hdr_w = put(hdr_w, 72'(cancel_w), 1);
          hdr_w = put(hdr_w, 72'h0, ctrl_reg[chef_pkg::CTRL_SC] ?
                      chef_pkg::W_RSV_SC : chef_pkg::W_RSV_OFDM);
        end else begin
          hdr_w = put(hdr_w, 72'(ppow_w), 1);
          hdr_w = put(hdr_w, 72'(pow_w), 1);
          hdr_w = put(hdr_w, 72'(cancel_w), 1);
          hdr_w = put(hdr_w, 72'(amr_w), chef_pkg::W_AMR);
          hdr_w = put(hdr_w, 72'(mtype_w), 2);
          hdr_w = put(hdr_w, 72'(mi_w), W_RATE_V2);
          hdr_w = put(hdr_w, 72'(mr_w), W_RATE_V2);
          hdr_w = put(hdr_w, 72'(aux_w), 2);
          hdr_w = put(hdr_w, 72'(sched_w), 2);
          hdr_w = put(hdr_w, 72'(req_w), chef_pkg::W_REQ);
          hdr_w = put(hdr_w, 72'(ack_w), W_ACK_V2);
          hdr_w = put(hdr_w, 72'(val_w), W_VAL_V2);
          hdr_w = put(hdr_w, 72'h0, W_RSV_V2);
        end
      end
      chef_pkg::KIND_CIRCUIT: begin
        sig_en_w = 1'b1;
        hdr_w = put(hdr_w, 72'(chef_pkg::CI_CIRCUIT), 2);
        hdr_w = put(hdr_w, 72'(mr_w), chef_pkg::W_AMR);
        hdr_w = put(hdr_w, 72'(pow_w), 1);
        hdr_w = put(hdr_w, 72'(ack_w), chef_pkg::W_ACK);
      end
      chef_pkg::KIND_TRAFFIC: begin
        sig_en_w = 1'b1;
        hdr_w = put(hdr_w, 72'(chef_pkg::CI_TRAFFIC), 2);
        hdr_w = put(hdr_w, 72'(mr_w), chef_pkg::W_AMR);
        hdr_w = put(hdr_w, 72'(pow_w), 1);
      end
      default: begin
        // Extension frames carry no header; the stream rate symbol goes out only while no downlink fallback is set.
        sig_en_w = ~fail_reg;
      end
    endcase
  end

  // ==========================================================================
  // Serialiser: signal symbol first, outside the CRC span, then the header
  logic [255:0] sh_reg;
  logic [3:0]   sig_sh_reg;
  logic [8:0]   cnt_reg;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ser_reg        <= chef_pkg::SER_IDLE;
      sh_reg         <= '0;
      sig_sh_reg     <= 4'h0;
      cnt_reg        <= 9'h000;
      hdr_bit_out    <= 1'b0;
      hdr_valid_out  <= 1'b0;
      hdr_crc_en_out <= 1'b0;
      hdr_last_out   <= 1'b0;
    end else begin
      hdr_valid_out <= 1'b0;
      hdr_last_out  <= 1'b0;
      case (ser_reg)
        chef_pkg::SER_IDLE: begin
          if (go_hdr_w) begin
            sh_reg     <= hdr_w.bits;
            sig_sh_reg <= sig_w;
            cnt_reg    <= sig_en_w ? 9'(chef_pkg::SIG_W) : hdr_w.len;
            ser_reg    <= sig_en_w ? chef_pkg::SER_SIG : chef_pkg::SER_HDR;
          end
        end
        chef_pkg::SER_SIG: begin
          hdr_bit_out    <= sig_sh_reg[3];
          hdr_valid_out  <= 1'b1;
          hdr_crc_en_out <= 1'b0;
          sig_sh_reg     <= {sig_sh_reg[2:0], 1'b0};
          cnt_reg        <= cnt_reg - 9'h001;
          if (cnt_reg == 9'h001) begin
            cnt_reg <= hdr_w.len;
            ser_reg <= chef_pkg::SER_HDR;
          end
        end
        chef_pkg::SER_HDR: begin
          if (cnt_reg == 9'h000) begin
            ser_reg <= chef_pkg::SER_IDLE;
          end else begin
            hdr_bit_out    <= sh_reg[255];
            hdr_valid_out  <= 1'b1;
            hdr_crc_en_out <= 1'b1;
            hdr_last_out   <= cnt_reg == 9'h001;
            sh_reg         <= {sh_reg[254:0], 1'b0};
            cnt_reg        <= cnt_reg - 9'h001;
          end
        end
        default: ser_reg <= chef_pkg::SER_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Acknowledgement symbol, repeated on every data block of the half-slot except the last one when sounding
  logic [2:0] ack_idx_reg;
  wire [2:0] ack_len_w = ctrl_reg[chef_pkg::CTRL_LEN3] ? 3'(chef_pkg::DATA_LEN3)
                                                       : 3'(chef_pkg::DATA_LEN4);
  wire ack_lastblk_w = ack_idx_reg == ack_len_w - 3'h1;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_act_reg      <= 1'b0;
      ack_idx_reg      <= 3'h0;
      ack_sym_out      <= '0;
      ack_valid_out    <= 1'b0;
      ack_puncture_out <= 1'b0;
    end else begin
      ack_valid_out    <= 1'b0;
      ack_puncture_out <= 1'b0;
      if (go_ack_w) begin
        ack_act_reg <= 1'b1;
        ack_idx_reg <= 3'h0;
      end else if (ack_act_reg && data_block_in) begin
        ack_sym_out <= ack_map(ctrl_reg[chef_pkg::CTRL_ACK_TWO],
                               ctrl_reg[chef_pkg::CTRL_ACK_LSB +: 2]);
        // The sounding pilot takes the final symbol, so it is blanked.
        ack_puncture_out <= ack_lastblk_w & ctrl_reg[chef_pkg::CTRL_SOUND];
        ack_valid_out    <= ~(ack_lastblk_w & ctrl_reg[chef_pkg::CTRL_SOUND]);
        ack_idx_reg      <= ack_idx_reg + 3'h1;
        if (ack_lastblk_w) ack_act_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Quality report: (20, A) block code, then QPSK, one symbol per data block
  logic [19:0] code_w, code_reg;
  logic [3:0]  cqi_idx_reg;
  always_comb begin
    code_w = 20'h0_0000;
    for (int i = 0; i < chef_pkg::W_CQI; i++) begin
      for (int k = 0; k < chef_pkg::CQI_A_MAX; k++) begin
        if (k < int'(cqi_reg[19:16]))
          code_w[i] = code_w[i] ^ (cqi_reg[k] & cqi_basis(i, k));
      end
    end
  end
  wire [4:0] cqi_bit_w = {cqi_idx_reg, 1'b0};
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cqi_act_reg   <= 1'b0;
      cqi_idx_reg   <= 4'h0;
      code_reg      <= 20'h0_0000;
      cqi_sym_out   <= '0;
      cqi_valid_out <= 1'b0;
    end else begin
      cqi_valid_out <= 1'b0;
      if (go_cqi_w) begin
        cqi_act_reg <= 1'b1;
        cqi_idx_reg <= 4'h0;
        code_reg    <= code_w;
      end else if (cqi_act_reg && data_block_in) begin
        cqi_sym_out.re <= code_reg[cqi_bit_w] ? 2'sb11 : 2'sb01;
        cqi_sym_out.im <= code_reg[cqi_bit_w + 5'h01] ? 2'sb11 : 2'sb01;
        cqi_valid_out  <= 1'b1;
        cqi_idx_reg    <= cqi_idx_reg + 4'h1;
        if (cqi_idx_reg == 4'(chef_pkg::CQI_SYMS - 1)) cqi_act_reg <= 1'b0;
      end
    end
  end

  assign prdata_out        = prdata_reg;
  assign pready_out        = pready_reg;
  assign pslverr_out       = pslverr_reg;
  assign timing_offset_out = timing_reg;
  assign power_level_out   = power_reg;
  assign primary_power_out = ppower_reg;
  assign dl_fallback_out   = fail_reg;
  assign dl_effective_out  = eff_reg;
endmodule : chef_framer
`default_nettype wire

// ---- tb/chef_props.sv ----
// Concurrent checks on the control header framer ports.
`timescale 1ns/1ps
`default_nettype none
module chef_props (
  input wire logic               clock_in,
  input wire logic               rst_b_in,
  input wire logic               psel_in,
  input wire logic               penable_in,
  input wire logic               pready_out,
  input wire logic               pslverr_out,
  input wire logic               hdr_valid_out,
  input wire logic               hdr_last_out,
  input wire logic               ack_valid_out,
  input wire logic               ack_puncture_out,
  input wire logic               dl_hdr_valid_in,
  input wire logic               dl_crc_ok_in,
  input wire logic               dl_fallback_out,
  input wire logic signed [7:0]  timing_offset_out,
  input wire logic signed [7:0]  power_level_out,
  input wire chef_pkg::chef_dl_t dl_effective_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  ready_after_setup_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  ready_cause_a: assert property (pready_out |-> $past(psel_in && !penable_in))
    else $error("ready without setup");
  err_with_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  punct_excl_a: assert property (ack_puncture_out |-> !ack_valid_out)
    else $error("puncture with valid");
  last_bit_a: assert property (hdr_last_out |-> hdr_valid_out ##1 !hdr_valid_out)
    else $error("bad last bit");
  fail_flag_a: assert property (dl_hdr_valid_in && !dl_crc_ok_in |=> dl_fallback_out)
    else $error("fallback not set");
  fail_hold_a: assert property (dl_hdr_valid_in && !dl_crc_ok_in |=>
    $stable(timing_offset_out) && $stable(power_level_out))
    else $error("timing or power moved");
  fail_zero_a: assert property (dl_fallback_out |->
    !dl_effective_out.grant && dl_effective_out.mtype == 2'h0 && dl_effective_out.aux == 2'h0)
    else $error("fallback fields not zero");
  cover property (hdr_last_out);
  cover property (ack_puncture_out);
  cover property (dl_fallback_out);
endmodule : chef_props
bind chef_framer chef_props chk_i (.*);
`default_nettype wire

// ---- tb/chef_peer.sv ----
// Downlink peer model: data block pacing and decoded header delivery.
`timescale 1ns/1ps
`default_nettype none
module chef_peer (
  input  wire logic          clock_in,
  output logic               data_block_in,
  output logic               dl_hdr_valid_in,
  output logic               dl_crc_ok_in,
  output chef_pkg::chef_dl_t dl_fields_in
);
  logic               pend = 1'b0;
  logic               pok;
  logic [1:0]         ph = 2'h0;
  chef_pkg::chef_dl_t pf;
  initial begin
    data_block_in = 1'b0;
    dl_hdr_valid_in = 1'b0;
    dl_crc_ok_in = 1'b0;
    dl_fields_in = '0;
  end
  task send(input logic ok, input chef_pkg::chef_dl_t fl);
    pok = ok;
    pf = fl;
    pend = 1'b1;
  endtask : send
  // Between headers the fields toggle, so a stale value can never pass for a fresh one.
  always @(posedge clock_in) begin
    ph <= ph + 2'h1;
    data_block_in <= (ph == 2'h0);
    dl_hdr_valid_in <= pend;
    dl_crc_ok_in <= pend ? pok : ~dl_crc_ok_in;
    dl_fields_in <= pend ? pf : ~dl_fields_in;
    pend <= 1'b0;
  end
endmodule : chef_peer
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the control header framer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_in, rst_b_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic data_block_in, dl_hdr_valid_in, dl_crc_ok_in, hdr_bit_out, hdr_valid_out;
  logic hdr_crc_en_out, hdr_last_out, ack_valid_out, ack_puncture_out, cqi_valid_out;
  logic dl_fallback_out, er, ok, two;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, r;
  logic signed [7:0] timing_offset_out, power_level_out, primary_power_out;
  logic [1:0] b;
  logic [19:0] cw;
  logic [12:0] qa;
  logic [3:0] tw[4] = '{4'h4, 4'h3, 4'h1, 4'hC};
  chef_pkg::chef_dl_t dl_fields_in, dl_effective_out, f, lg, e;
  chef_pkg::chef_sym_t ack_sym_out, cqi_sym_out;
  int n_mismatch = 0, checks = 0, i, t, k, p, np, nv, len, tm = 0, pw = 0, pp = 0;
  int dt[4] = '{0, -1, 2, 1};
  chef_framer uut (.*);
  chef_peer peer (.*);
  always #20 clock_in = ~clock_in;
  task print_verdict;
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [63:0] g, input logic [63:0] x);
    checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge clock_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    for (j = 0; j < 20 && pready_out !== 1'b1; j++) @(posedge clock_in);
    if (j == 20) begin
      n_mismatch++;
      print_verdict;
    end
    r = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  // Serial header capture: bit order, CRC coverage and the last-bit marker together.
  task hdr(input logic [31:0] c, input logic [31:0] fl, input logic [63:0] x, input int n, ns);
    apb(1, chef_pkg::ADDR_RATE, 32'hA);
    apb(1, chef_pkg::ADDR_FIELDS, fl);
    // The header is built from the stored control word, so the kind lands before the go bit.
    apb(1, chef_pkg::ADDR_CTRL, c);
    apb(1, chef_pkg::ADDR_CTRL, c | 32'h400);
    k = 0;
    for (t = 0; t < 60; t++) begin
      @(posedge clock_in);
      if (hdr_valid_out === 1'b1) begin
        chk(hdr_bit_out, x[n-1-k]);
        chk(hdr_crc_en_out, k >= ns);
        chk(hdr_last_out, k == n - 1);
        k++;
      end
    end
    chk(k, n);
  endtask : hdr
  initial begin
    clock_in = 0;
    rst_b_in = 0;
    psel_in = 0;
    penable_in = 0;
    pwrite_in = 0;
    paddr_in = 0;
    pwdata_in = 0;
    lg = '0;
    void'($urandom(32'h24B11CE5));
    repeat (8) @(posedge clock_in);
    rst_b_in <= 1'b1;
    apb(0, chef_pkg::ADDR_CTRL, 0);
    chk(r, chef_pkg::CTRL_RESET);
    apb(0, 8'h24, 0);
    chk({er, r}, 33'h1_0000_0000);
    hdr(0, 32'h80, 16'h1, 3, 0);
    hdr(32'h8, 32'hC80, 16'h516, 11, 4);
    for (i = 0; i < 6; i++) begin
      two = i < 4;
      b = i[1:0];
      len = i[1] ? 3 : 4;
      apb(1, chef_pkg::ADDR_CTRL, (two << 5) | (i[1] << 6) | (i[0] << 7) | (b << 8) | 32'h800);
      np = 0;
      nv = 0;
      for (t = 0; t < 40; t++) begin
        @(posedge clock_in);
        if (ack_puncture_out === 1'b1) begin
          np++;
          chk(nv, len - 1);
        end
        if (ack_valid_out === 1'b1) begin
          nv++;
          chk(ack_sym_out, two ? tw[b] : (b[0] ? 4'hC : 4'h4));
        end
      end
      chk(nv + np, len);
      chk(np, i[0]);
    end
    qa = 13'($urandom);
    cw = '0;
    // Quality code model: the fixed basis pattern agreed for the (20, A) code.
    for (i = 0; i < 20; i++) begin
      for (k = 0; k < 13; k++) begin
        p = (i + 1) * (k + 3) + k;
        cw[i] = cw[i] ^ (qa[k] & (p[2] ^ p[0]));
      end
    end
    apb(1, chef_pkg::ADDR_CQI, 32'hD_0000 | qa);
    apb(1, chef_pkg::ADDR_CTRL, 32'h1000);
    nv = 0;
    for (t = 0; t < 60; t++) begin
      @(posedge clock_in);
      if (cqi_valid_out === 1'b1) begin
        chk(cqi_sym_out, {cw[2 * nv] ? 2'h3 : 2'h1, cw[2 * nv + 1] ? 2'h3 : 2'h1});
        nv++;
      end
    end
    chk(nv, 10);
    for (i = 0; i < 12; i++) begin
      f = chef_pkg::chef_dl_t'(29'($urandom));
      ok = (i % 5) > 1;
      #1 peer.send(ok, f);
      repeat (3) @(posedge clock_in);
      if (ok) begin
        tm += dt[f.shift];
        pw += f.pow ? 1 : -1;
        pp += f.ppow ? 1 : -1;
        lg = f;
      end
      e = lg;
      if (!ok) begin
        e.grant = 0;
        e.mtype = 0;
        e.aux = 0;
      end
      chk(dl_fallback_out, !ok);
      chk(timing_offset_out[7:0], tm[7:0]);
      chk(power_level_out[7:0], pw[7:0]);
      chk(primary_power_out[7:0], pp[7:0]);
      chk(dl_effective_out, e);
    end
    apb(0, chef_pkg::ADDR_STATUS, 0);
    chk({r[3], r[15:8]}, {1'b1, tm[7:0]});
    hdr(32'h2, 32'h100, {4'hA, 2'h1, 4'h0, 1'h1, {36{1'h1}}}, 47, 4);
    hdr(32'h4, 32'h0, 64'h0, 0, 0);
    print_verdict;
  end
endmodule : tb
`default_nettype wire
